// file: bus_state_pkg.sv
// Purpose : Shared constants for the instrument bus remote/local logic
// Assumes : 25 MHz core clock, eight-bit bus data
// Notes   : Command byte codes follow the standard multiline message set
package bus_state_pkg;
  localparam logic [4:0] ADDR_DEFAULT = 5'h07;
  localparam logic [4:0] ADDR_MAX     = 5'h1E;
  localparam logic [4:0] ADDR_UNADDR  = 5'h1F;
  localparam logic [7:0] CMD_GTL      = 8'h01;
  localparam logic [7:0] CMD_SDC      = 8'h04;
  localparam logic [7:0] CMD_GET      = 8'h08;
  localparam logic [7:0] CMD_LLO      = 8'h11;
  localparam logic [7:0] CMD_DCL      = 8'h14;
  localparam logic [7:0] CMD_SPE      = 8'h18;
  localparam logic [7:0] CMD_SPD      = 8'h19;
  localparam logic [1:0] GRP_LISTEN   = 2'h1;
  localparam logic [1:0] GRP_TALK     = 2'h2;
  localparam int         IFC_MIN_US   = 100;
endpackage

// file: bus_sync3.sv
// Purpose : Three-stage synchroniser for one pin level
// Assumes : Pin is asynchronous to core_clk
// Notes   : Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module bus_sync3 (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic pin,
  output var  logic level
);
  logic [2:0] s_q;
  logic [2:0] s_d;
  logic       level_q;
  logic       level_d;

  // Next values; stage one feeds only stage two
  always_comb begin
    s_d     = {s_q[1], s_q[0], pin};
    level_d = (s_q[1] == s_q[2]) ? s_q[2] : level_q;
  end

  // Registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q     <= 3'h0;
      level_q <= 1'b0;
    end else begin
      s_q     <= s_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule
`default_nettype wire

// file: bus_remote_ctrl.sv
// Purpose : Device-side bus interface states: address, remote, lockout, clears
// Assumes : Command bytes arrive as one-cycle strobes already decoded for ATN
// Notes   : Handshake timing and data transfer live elsewhere
`timescale 1ns/1ps
`default_nettype none
module bus_remote_ctrl
  import bus_state_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       ifc_pin,
  input  wire logic       ren_pin,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       addr_wr,
  input  wire logic [4:0] addr_in,
  input  wire logic       local_key,
  input  wire logic       panel_key,
  input  wire logic       trig_src_bus,
  input  wire logic [7:0] status_byte,
  output var  logic [4:0] primary_addr,
  output var  logic       remote_indicator,
  output var  logic       talk_indicator,
  output var  logic       listen_indicator,
  output var  logic       lockout,
  output var  logic       panel_enable,
  output var  logic       panel_key_accept,
  output var  logic       dev_clear,
  output var  logic       trigger,
  output var  logic       spoll_mode,
  output var  logic       talk_data_valid,
  output var  logic [7:0] talk_data
);
  import bus_state_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic ifc_s;
  logic ren_s;

  bus_sync3 u_ifc (.core_clk(core_clk), .srst(srst), .pin(ifc_pin), .level(ifc_s));
  bus_sync3 u_ren (.core_clk(core_clk), .srst(srst), .pin(ren_pin), .level(ren_s));

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [4:0] addr_q, addr_d;
  logic       rem_q, rem_d;
  logic       tacs_q, tacs_d;
  logic       lacs_q, lacs_d;
  logic       llo_q, llo_d;
  logic       spe_q, spe_d;
  logic       clr_q, clr_d;
  logic       trg_q, trg_d;
  logic       pka_q, pka_d;
  logic       tdv_q, tdv_d;
  logic [7:0] tdat_q, tdat_d;
  logic       pen_q, pen_d;
  logic [1:0] grp;
  logic [4:0] fld;
  logic       my_listen;
  logic       my_talk;

  assign grp       = cmd_byte[6:5];
  assign fld       = cmd_byte[4:0];
  assign my_listen = cmd_valid && grp == GRP_LISTEN && fld == addr_q;
  assign my_talk   = cmd_valid && grp == GRP_TALK && fld == addr_q;

  // Next-state logic; interface clear beats addressing, remote and poll commands in the same cycle; lockout, clears and triggers still act
  always_comb begin
    addr_d = addr_q;
    rem_d  = rem_q;
    tacs_d = tacs_q;
    lacs_d = lacs_q;
    llo_d  = llo_q;
    spe_d  = spe_q;
    clr_d  = 1'b0;
    trg_d  = 1'b0;
    pka_d  = panel_key && !rem_q;
    tdv_d  = 1'b0;
    tdat_d = tdat_q;
    // Out-of-range writes are dropped so the address never reaches 31
    if (addr_wr && addr_in <= ADDR_MAX)
      addr_d = addr_in;
    if (!ren_s) begin
      rem_d = 1'b0;
      llo_d = 1'b0;
    end
    if (local_key && rem_q && !llo_q)
      rem_d = 1'b0;
    if (cmd_valid) begin
      if (my_listen) begin
        lacs_d = 1'b1;
        tacs_d = 1'b0;
        if (ren_s)
          rem_d = 1'b1;
      end else if (grp == GRP_LISTEN && fld == ADDR_UNADDR) begin
        lacs_d = 1'b0;
      end
      if (my_talk) begin
        tacs_d = 1'b1;
        lacs_d = 1'b0;
      end else if (grp == GRP_TALK) begin
        tacs_d = 1'b0;
      end
      unique case (cmd_byte)
        CMD_GTL: if (lacs_q) begin
          rem_d = 1'b0;
          llo_d = 1'b0;
        end
        CMD_LLO: if (ren_s) llo_d = 1'b1;
        CMD_DCL: clr_d = 1'b1;
        CMD_SDC: clr_d = lacs_q;
        CMD_GET: trg_d = lacs_q && trig_src_bus;
        CMD_SPE: spe_d = 1'b1;
        CMD_SPD: spe_d = 1'b0;
        default: ;
      endcase
    end
    if (spe_d && tacs_d) begin
      tdv_d  = 1'b1;
      tdat_d = status_byte;
    end
    // Settings and stored data are outside this block, so clear leaves them
    if (ifc_s) begin
      rem_d  = 1'b0;
      tacs_d = 1'b0;
      lacs_d = 1'b0;
      spe_d  = 1'b0;
      tdv_d  = 1'b0;
    end
    // Panel enable kept in its own flop so the output is registered
    pen_d = !rem_d;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_q <= ADDR_DEFAULT;
      rem_q  <= 1'b0;
      tacs_q <= 1'b0;
      lacs_q <= 1'b0;
      llo_q  <= 1'b0;
      spe_q  <= 1'b0;
      clr_q  <= 1'b0;
      trg_q  <= 1'b0;
      pka_q  <= 1'b0;
      tdv_q  <= 1'b0;
      tdat_q <= 8'h00;
      pen_q  <= 1'b1;
    end else begin
      addr_q <= addr_d;
      rem_q  <= rem_d;
      tacs_q <= tacs_d;
      lacs_q <= lacs_d;
      llo_q  <= llo_d;
      spe_q  <= spe_d;
      clr_q  <= clr_d;
      trg_q  <= trg_d;
      pka_q  <= pka_d;
      tdv_q  <= tdv_d;
      tdat_q <= tdat_d;
      pen_q  <= pen_d;
    end
  end

  // Outputs straight from flip-flops
  assign primary_addr     = addr_q;
  assign remote_indicator = rem_q;
  assign talk_indicator   = tacs_q;
  assign listen_indicator = lacs_q;
  assign lockout          = llo_q;
  assign panel_enable     = pen_q;
  assign panel_key_accept = pka_q;
  assign dev_clear        = clr_q;
  assign trigger          = trg_q;
  assign spoll_mode       = spe_q;
  assign talk_data_valid  = tdv_q;
  assign talk_data        = tdat_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_ADDR_RANGE: assert property (@(posedge core_clk) disable iff (srst)
    addr_q <= ADDR_MAX) else $error("address out of range");
  AST_REM_CAUSE: assert property (@(posedge core_clk) disable iff (srst)
    $rose(rem_q) |-> $past(my_listen) && $past(ren_s)) else $error("remote without listen");
  AST_TALK: assert property (@(posedge core_clk) disable iff (srst)
    my_talk && !ifc_s |=> tacs_q) else $error("talk address missed");
  AST_LOCAL_KEY: assert property (@(posedge core_clk) disable iff (srst)
    local_key && rem_q && !llo_q && !my_listen |=> !rem_q) else $error("local key ignored");
  AST_IFC: assert property (@(posedge core_clk) disable iff (srst)
    ifc_s |=> !rem_q && !tacs_q && !lacs_q) else $error("clear not applied");
  AST_LLO: assert property (@(posedge core_clk) disable iff (srst)
    llo_q && rem_q && ren_s && !ifc_s && !(cmd_valid && cmd_byte == CMD_GTL) |=> rem_q)
    else $error("lockout broken");
  AST_SDC: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && cmd_byte == CMD_SDC |=> dev_clear == $past(lacs_q)) else $error("sdc wrong");
  AST_DCL: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && cmd_byte == CMD_DCL ##1 !(cmd_valid && (cmd_byte == CMD_DCL || cmd_byte == CMD_SDC))
    |-> dev_clear ##1 !dev_clear) else $error("dcl pulse wrong");
  AST_GET: assert property (@(posedge core_clk) disable iff (srst)
    trigger |-> $past(lacs_q) && $past(trig_src_bus)) else $error("stray trigger");
  AST_UNL: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && grp == GRP_LISTEN && fld == ADDR_UNADDR |=> !lacs_q) else $error("unlisten missed");
  AST_SPOLL: assert property (@(posedge core_clk) disable iff (srst)
    talk_data_valid |-> spe_q && tacs_q) else $error("status byte outside poll");
endmodule
`default_nettype wire

// file: bus_ctrl_model.sv
// Purpose : Controller-side model that drives bus pins and command bytes
// Assumes : All changes land on the falling edge of core_clk
// Notes   : Idle command lines show the inverted last byte, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model #(
  parameter int IFC_HOLD = 2500
) (
  input  wire logic       core_clk,
  output var  logic       ifc_pin,
  output var  logic       ren_pin,
  output var  logic       cmd_valid,
  output var  logic [7:0] cmd_byte
);
  // ----------------------------------------
  // Idle levels and controller requests
  // ----------------------------------------
  initial begin
    ifc_pin   = 1'b0;
    ren_pin   = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte  = 8'hFF;
  end
  // One-cycle command byte; never claims the device address itself
  task automatic send(input logic [7:0] b);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_byte  = b;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_byte  = ~b;
  endtask
  // Level change, then room for the three-stage synchroniser
  task automatic set_ren(input logic v);
    @(negedge core_clk);
    ren_pin = v;
    repeat (6) @(negedge core_clk);
  endtask
  // Clear held 100 us at 40 ns a cycle
  task automatic pulse_ifc();
    @(negedge core_clk);
    ifc_pin = 1'b1;
    repeat (IFC_HOLD) @(negedge core_clk);
    ifc_pin = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose : Self-checking bench for the bus remote/local block
// Assumes : Inputs change on the falling clock edge
// Notes   : Pin levels are given six cycles to pass the synchroniser
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bus_state_pkg::*;
  logic       core_clk, srst, ifc_pin, ren_pin, cmd_valid, addr_wr, local_key, panel_key, trig_src_bus;
  logic [7:0] cmd_byte, status_byte, talk_data;
  logic [4:0] addr_in, primary_addr;
  logic       remote_indicator, talk_indicator, listen_indicator, lockout, panel_enable;
  logic       panel_key_accept, dev_clear, trigger, spoll_mode, talk_data_valid;
  int         errors, n_tests;
  // ----------------------------------------
  // Clock, instances, helpers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  bus_ctrl_model ctl (
    .core_clk  (core_clk),
    .ifc_pin   (ifc_pin),
    .ren_pin   (ren_pin),
    .cmd_valid (cmd_valid),
    .cmd_byte  (cmd_byte)
  );
  bus_remote_ctrl dut (
    .core_clk         (core_clk),
    .srst             (srst),
    .ifc_pin          (ifc_pin),
    .ren_pin          (ren_pin),
    .cmd_valid        (cmd_valid),
    .cmd_byte         (cmd_byte),
    .addr_wr          (addr_wr),
    .addr_in          (addr_in),
    .local_key        (local_key),
    .panel_key        (panel_key),
    .trig_src_bus     (trig_src_bus),
    .status_byte      (status_byte),
    .primary_addr     (primary_addr),
    .remote_indicator (remote_indicator),
    .talk_indicator   (talk_indicator),
    .listen_indicator (listen_indicator),
    .lockout          (lockout),
    .panel_enable     (panel_enable),
    .panel_key_accept (panel_key_accept),
    .dev_clear        (dev_clear),
    .trigger          (trigger),
    .spoll_mode       (spoll_mode),
    .talk_data_valid  (talk_data_valid),
    .talk_data        (talk_data)
  );
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle press; returns once the design has registered it
  task automatic hit(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  task automatic wr_addr(input logic [4:0] a);
    @(negedge core_clk);
    addr_in = a;
    addr_wr = 1'b1;
    @(negedge core_clk);
    addr_wr = 1'b0;
  endtask
  task automatic finish_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_remote();
    chk("addr", primary_addr, 8'h07);
    ctl.set_ren(1'b1);
    chk("rem", remote_indicator, 8'h00);
    ctl.send(8'h27);
    chk("rem", remote_indicator, 8'h01);
    chk("pen", panel_enable, 8'h00);
    hit(panel_key);
    chk("pka", panel_key_accept, 8'h00);
    hit(local_key);
    chk("rem", remote_indicator, 8'h00);
    chk("pen", panel_enable, 8'h01);
    hit(panel_key);
    chk("pka", panel_key_accept, 8'h01);
    ctl.send(8'h3F);
    chk("lsn", listen_indicator, 8'h00);
  endtask
  task automatic t_talk();
    ctl.set_ren(1'b0);
    ctl.send(8'h47);
    chk("tlk", talk_indicator, 8'h01);
    ctl.send(8'h5F);
    chk("tlk", talk_indicator, 8'h00);
    ctl.send(8'h47);
    ctl.send(8'h27);
    chk("tlk", talk_indicator, 8'h00);
  endtask
  task automatic t_lockout();
    ctl.set_ren(1'b1);
    ctl.send(8'h27);
    ctl.send(CMD_LLO);
    chk("llo", lockout, 8'h01);
    hit(local_key);
    chk("rem", remote_indicator, 8'h01);
    ctl.send(CMD_GTL);
    chk("rem", remote_indicator, 8'h00);
    chk("llo", lockout, 8'h00);
  endtask
  task automatic t_clear();
    ctl.send(CMD_DCL);
    chk("dcl", dev_clear, 8'h01);
    ctl.send(8'h3F);
    ctl.send(CMD_SDC);
    chk("sdc", dev_clear, 8'h00);
    ctl.send(CMD_DCL);
    chk("dcl", dev_clear, 8'h01);
    ctl.send(8'h27);
    ctl.send(CMD_SDC);
    chk("sdc", dev_clear, 8'h01);
    ctl.send(CMD_GET);
    chk("get", trigger, 8'h00);
    trig_src_bus = 1'b1;
    ctl.send(CMD_GET);
    chk("get", trigger, 8'h01);
    ctl.send(8'h3F);
    ctl.send(CMD_GET);
    chk("get", trigger, 8'h00);
  endtask
  task automatic t_poll();
    status_byte = 8'hA5;
    ctl.send(CMD_SPE);
    chk("spm", spoll_mode, 8'h01);
    ctl.send(8'h47);
    chk("spv", talk_data_valid, 8'h01);
    chk("spd", talk_data, 8'hA5);
    ctl.send(CMD_SPD);
    chk("spv", talk_data_valid, 8'h00);
    chk("spm", spoll_mode, 8'h00);
  endtask
  // Both addressed states and remote must fall on a clear
  task automatic t_ifc();
    ctl.set_ren(1'b1);
    ctl.send(8'h27);
    ctl.pulse_ifc();
    chk("rem", remote_indicator, 8'h00);
    chk("lsn", listen_indicator, 8'h00);
    ctl.send(8'h47);
    ctl.pulse_ifc();
    chk("tlk", talk_indicator, 8'h00);
    chk("addr", primary_addr, 8'h07);
  endtask
  // Old address must stop matching once a new one is stored
  task automatic t_addr();
    wr_addr(5'h1F);
    chk("addr", primary_addr, 8'h07);
    wr_addr(5'h1E);
    chk("addr", primary_addr, 8'h1E);
    ctl.send(8'h27);
    chk("lsn", listen_indicator, 8'h00);
    ctl.send(8'h3E);
    chk("lsn", listen_indicator, 8'h01);
    ctl.send(8'h47);
    chk("lsn", listen_indicator, 8'h01);
    chk("tlk", talk_indicator, 8'h00);
  endtask
  // Mid-run reset must bring back the power-on values
  task automatic t_reset();
    @(negedge core_clk);
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    chk("addr", primary_addr, 8'h07);
    chk("pen", panel_enable, 8'h01);
    chk("lsn", listen_indicator, 8'h00);
    chk("tdat", talk_data, 8'h00);
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    srst = 1'b1;
    addr_wr = 1'b0;
    addr_in = 5'h00;
    local_key = 1'b0;
    panel_key = 1'b0;
    trig_src_bus = 1'b0;
    status_byte = 8'h00;
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    t_remote();
    t_talk();
    t_lockout();
    t_clear();
    t_poll();
    t_ifc();
    t_addr();
    t_reset();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
